/* ee_cfg.svh */
// shared constants for the two-wire serial memory link
`ifndef EE_CFG_SVH
`define EE_CFG_SVH
`define CLK_MHZ 200
`define ADDR_W 12
`define BYTE_BITS 4'h8
`define FRAME_BITS 4'h9
`define DEV_TYPE_CODE 4'h6 // arbitrary value
`define TYPE_FIELD 7:4
`define SEL_FIELD 3:1
`define RD_BIT 0
`define AH_FIELD 11:8
`define AL_FIELD 7:0
`define PROG_TIME_NS 5000
`define PROG_CYCLES ((`PROG_TIME_NS * `CLK_MHZ + 999) / 1000)
`define SCL_QUARTER_NS 125
`define SCL_QUARTER ((`SCL_QUARTER_NS * `CLK_MHZ) / 1000)
`define OD_LOW 1'h0
`define REG_CMD 8'h00
`define REG_WDATA 8'h04
`define REG_STATUS 8'h08
`define REG_RDATA 8'h0C
`define CMD_OP 1:0
`define CMD_SEL 6:4
`define CMD_COUNT 15:8
`define CMD_ADDR 27:16
`define ST_BUSY 0
`define ST_NACK 1
`define ST_FULL 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* ee_pkg.sv */
// types shared by both ends of the two-wire memory link
`default_nettype none
package ee_pkg;
  typedef enum logic [1:0] {OP_POLL, OP_WRITE, OP_CUR_READ, OP_RAND_READ} op_t;
  typedef enum logic [2:0] {D_IDLE, D_CTRL, D_AHI, D_ALO, D_WDAT, D_RDAT, D_IGN} dst_t;
  typedef enum logic [2:0] {M_IDLE, M_START, M_SEND, M_RECV, M_WAIT, M_STOP} mst_t;
  typedef enum logic [2:0] {W_CTRLW, W_AH, W_AL, W_DATA, W_CTRLR} what_t;
endpackage
`default_nettype wire

/* two_wire_if.sv */
// open-drain two-wire bus joining the controller and the memory
`timescale 1ns/10ps
`default_nettype none
interface two_wire_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // wired-and of every enabled driver, pulled up otherwise
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(d_sda_oe && !d_sda_o);
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport device (output d_sda_o, d_sda_oe, input scl, sda);
endinterface
`default_nettype wire

/* ee_dev.sv */
// serial memory slave: read path, address pointer and busy polling
`timescale 1ns/10ps
`default_nettype none
`include "ee_cfg.svh"
module ee_dev #(
  parameter int ADDR_W = `ADDR_W,
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter logic [3:0] TYPE_CODE = `DEV_TYPE_CODE
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // chip select straps
  input wire logic i_chip_select_hi_pin,
  input wire logic i_chip_select_mid_pin,
  input wire logic i_chip_select_lo_pin,
  // two-wire bus
  two_wire_if.device bus,
  // programming cycle under way
  output logic o_busy
);
  localparam int BW = $clog2(PROG_CYCLES + 1);
  localparam int DEPTH = 1 << ADDR_W;

  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [1:0] s3_q;
  logic scl;
  logic sda;
  logic [2:0] sel;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  ee_pkg::dst_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] hi_q, hi_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d;
  logic rd_q, rd_d;
  logic mack_q, mack_d;
  logic wrote_q, wrote_d;
  logic oe_q, oe_d;
  logic [BW-1:0] busy_q, busy_d;
  logic mem_we;
  logic [7:0] mem [DEPTH];
  logic [7:0] mem_rd;

  // two-stage synchroniser for bus lines and straps
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q <= 5'h1F;
      s2_q <= 5'h1F;
      s3_q <= 2'h3;
    end else begin
      s1_q <= {bus.scl, bus.sda, i_chip_select_hi_pin, i_chip_select_mid_pin,
               i_chip_select_lo_pin};
      s2_q <= s1_q;
      s3_q <= s2_q[4:3];
    end
  end

  // line events from the synchronised levels
  assign scl = s2_q[4];
  assign sda = s2_q[3];
  assign sel = s2_q[2:0];
  assign start = s3_q[1] && scl && s3_q[0] && !sda;
  assign stop = s3_q[1] && scl && !s3_q[0] && sda;
  assign rise = !s3_q[1] && scl;
  assign fall = s3_q[1] && !scl;

  // storage array, written by received data bytes
  always_ff @(posedge i_clk) begin
    if (mem_we) begin
      mem[ptr_q] <= sh_q;
    end
  end
  assign mem_rd = mem[ptr_q];

  // protocol engine: frames of eight bits plus acknowledge
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    hi_d = hi_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    mack_d = mack_q;
    wrote_d = wrote_q;
    oe_d = oe_q;
    busy_d = busy_q;
    mem_we = 1'b0;
    if (busy_q != '0) begin
      busy_d = busy_q - 1'b1;
    end
    if (start) begin
      st_d = ee_pkg::D_CTRL;
      cnt_d = '0;
      oe_d = 1'b0;
    end else if (stop) begin
      st_d = ee_pkg::D_IDLE;
      oe_d = 1'b0;
      if (wrote_q) begin
        busy_d = BW'(PROG_CYCLES);
        wrote_d = 1'b0;
      end
    end else if (st_q != ee_pkg::D_IDLE && st_q != ee_pkg::D_IGN) begin
      if (rise) begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q < `BYTE_BITS) begin
          sh_d = {sh_q[6:0], sda};
        end else if (st_q == ee_pkg::D_RDAT) begin
          mack_d = !sda;
        end
      end else if (fall && cnt_q == `BYTE_BITS) begin
        // byte received: decide on acknowledge
        case (st_q)
          ee_pkg::D_CTRL: begin
            if (sh_q[`TYPE_FIELD] == TYPE_CODE && sh_q[`SEL_FIELD] == sel && busy_q == '0) begin
              oe_d = 1'b1;
              rd_d = sh_q[`RD_BIT];
            end else begin
              st_d = ee_pkg::D_IGN;
            end
          end
          ee_pkg::D_AHI: begin
            hi_d = sh_q;
            oe_d = 1'b1;
          end
          ee_pkg::D_ALO: begin
            ptr_d = ADDR_W'({hi_q, sh_q});
            oe_d = 1'b1;
          end
          ee_pkg::D_WDAT: begin
            mem_we = 1'b1;
            ptr_d = ptr_q + 1'b1;
            wrote_d = 1'b1;
            oe_d = 1'b1;
          end
          default: begin
            oe_d = 1'b0;
          end
        endcase
      end else if (fall && cnt_q == `FRAME_BITS) begin
        // acknowledge clock over: next byte
        cnt_d = '0;
        oe_d = 1'b0;
        case (st_q)
          ee_pkg::D_CTRL: begin
            if (rd_q) begin
              st_d = ee_pkg::D_RDAT;
            end else begin
              st_d = ee_pkg::D_AHI;
            end
          end
          ee_pkg::D_AHI: st_d = ee_pkg::D_ALO;
          ee_pkg::D_ALO: st_d = ee_pkg::D_WDAT;
          ee_pkg::D_WDAT: st_d = ee_pkg::D_WDAT;
          default: begin
            if (!mack_q) begin
              st_d = ee_pkg::D_IGN;
            end
          end
        endcase
        // load byte, pointer steps and wraps
        if ((st_q == ee_pkg::D_CTRL && rd_q) || (st_q == ee_pkg::D_RDAT && mack_q)) begin
          tx_d = mem_rd;
          ptr_d = ptr_q + 1'b1;
          oe_d = !mem_rd[7];
        end
      end else if (fall && st_q == ee_pkg::D_RDAT && cnt_q != '0) begin
        // shift out the data word msb first
        tx_d = {tx_q[6:0], 1'b0};
        oe_d = !tx_q[6];
      end
    end
  end

  // engine registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= ee_pkg::D_IDLE;
      cnt_q <= '0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      hi_q <= 8'h00;
      ptr_q <= '0;
      rd_q <= 1'b0;
      mack_q <= 1'b0;
      wrote_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      hi_q <= hi_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      mack_q <= mack_d;
      wrote_q <= wrote_d;
      oe_q <= oe_d;
      busy_q <= busy_d;
    end
  end

  // open-drain drive and status
  assign bus.d_sda_o = `OD_LOW;
  assign bus.d_sda_oe = oe_q;
  assign o_busy = busy_q != '0;
endmodule
`default_nettype wire

/* ee_master.sv */
// two-wire bus controller for the serial memory, run over axi4-lite
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ee_cfg.svh"
module ee_master #(
  parameter int QUARTER = `SCL_QUARTER,
  parameter logic [3:0] TYPE_CODE = `DEV_TYPE_CODE
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // axi4-lite write address and data
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // two-wire bus
  two_wire_if.master bus
);
  localparam int DW = $clog2(QUARTER + 1);

  logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d, bv_q, bv_d, rv_q, rv_d, go_q, go_d;
  logic [7:0] awa_q, awa_d, wb_q, wb_d, byte_q, byte_d, sh_q, sh_d, left_q, left_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, cmd_q, cmd_d, status;
  logic [3:0] ws_q, ws_d, bit_q, bit_d;
  logic [1:0] br_q, br_d, rr_q, rr_d, ph_q, ph_d;
  logic [DW-1:0] div_q, div_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d, nack_q, nack_d, full_q, full_d;
  logic s1_q, s2_q, sda, tick, busy, clr_full, set_full;
  ee_pkg::mst_t ms_q, ms_d;
  ee_pkg::what_t what_q, what_d;
  ee_pkg::op_t op;

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[i*8 +: 8] = n[i*8 +: 8];
      end
    end
  endfunction

  // byte sent on the bus for each step
  function automatic logic [7:0] tx_byte(ee_pkg::what_t w, logic [31:0] c, logic [7:0] d);
    logic [11:0] a;
    a = c[`CMD_ADDR];
    case (w)
      ee_pkg::W_CTRLW: tx_byte = {TYPE_CODE, c[`CMD_SEL], 1'b0};
      ee_pkg::W_CTRLR: tx_byte = {TYPE_CODE, c[`CMD_SEL], 1'b1};
      ee_pkg::W_AH: tx_byte = {4'h0, a[`AH_FIELD]};
      ee_pkg::W_AL: tx_byte = a[`AL_FIELD];
      default: tx_byte = d;
    endcase
  endfunction

  assign op = ee_pkg::op_t'(cmd_q[`CMD_OP]);
  assign busy = (ms_q != ee_pkg::M_IDLE) || go_q;
  assign o_awready = !aw_ok_q && !bv_q;
  assign o_wready = !w_ok_q && !bv_q;
  assign o_arready = !rv_q;

  // register slave: write pairs address and data, reads answer next cycle
  always_comb begin
    {aw_ok_d, awa_d, w_ok_d, wd_d, ws_d} = {aw_ok_q, awa_q, w_ok_q, wd_q, ws_q};
    {bv_d, br_d, rv_d, rd_d, rr_d} = {bv_q, br_q, rv_q, rd_q, rr_q};
    cmd_d = cmd_q;
    wb_d = wb_q;
    go_d = 1'b0;
    clr_full = 1'b0;
    status = 32'h0;
    status[`ST_BUSY] = busy;
    status[`ST_NACK] = nack_q;
    status[`ST_FULL] = full_q;
    if (i_awvalid && o_awready) begin
      aw_ok_d = 1'b1;
      awa_d = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_ok_d = 1'b1;
      wd_d = i_wdata;
      ws_d = i_wstrb;
    end
    if (bv_q && i_bready) begin
      bv_d = 1'b0;
    end
    if (aw_ok_q && w_ok_q) begin
      aw_ok_d = 1'b0;
      w_ok_d = 1'b0;
      bv_d = 1'b1;
      br_d = `RESP_OKAY;
      case (awa_q)
        `REG_CMD: begin
          if (!busy) begin
            cmd_d = merge(cmd_q, wd_q, ws_q);
            go_d = 1'b1;
          end
        end
        `REG_WDATA: begin
          if (!busy) begin
            wb_d = 8'(merge({24'h0, wb_q}, wd_q, ws_q));
          end
        end
        `REG_STATUS, `REG_RDATA: ;
        default: br_d = `RESP_SLVERR;
      endcase
    end
    if (rv_q && i_rready) begin
      rv_d = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      rv_d = 1'b1;
      rr_d = `RESP_OKAY;
      case (i_araddr)
        `REG_CMD: rd_d = cmd_q;
        `REG_WDATA: rd_d = {24'h0, wb_q};
        `REG_STATUS: rd_d = status;
        `REG_RDATA: begin
          rd_d = {24'h0, byte_q};
          clr_full = 1'b1;
        end
        default: begin
          rd_d = 32'h0;
          rr_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  // bus engine: four quarter phases per bit
  always_comb begin
    {ms_d, what_d, ph_d, bit_d, sh_d, left_d} = {ms_q, what_q, ph_q, bit_q, sh_q, left_q};
    {scl_oe_d, sda_oe_d, nack_d, byte_d} = {scl_oe_q, sda_oe_q, nack_q, byte_q};
    div_d = tick ? '0 : div_q + 1'b1;
    set_full = 1'b0;
    if (tick) begin
      ph_d = ph_q + 1'b1;
    end
    case (ms_q)
      ee_pkg::M_IDLE: begin
        div_d = '0;
        ph_d = 2'h0;
        if (go_q) begin
          ms_d = ee_pkg::M_START;
          what_d = (op == ee_pkg::OP_CUR_READ) ? ee_pkg::W_CTRLR : ee_pkg::W_CTRLW;
          left_d = cmd_q[`CMD_COUNT];
          nack_d = 1'b0;
        end
      end
      ee_pkg::M_START: begin
        if (tick) begin
          case (ph_q)
            2'h0: {scl_oe_d, sda_oe_d} = 2'h2;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b1;
            default: begin
              scl_oe_d = 1'b1;
              ms_d = ee_pkg::M_SEND;
              bit_d = 4'h0;
              sh_d = tx_byte(what_q, cmd_q, wb_q);
            end
          endcase
        end
      end
      ee_pkg::M_SEND: begin
        if (tick) begin
          case (ph_q)
            2'h0: sda_oe_d = (bit_q < `BYTE_BITS) && !sh_q[7];
            2'h2: scl_oe_d = 1'b0;
            2'h3: begin
              scl_oe_d = 1'b1;
              bit_d = bit_q + 1'b1;
              sh_d = {sh_q[6:0], 1'b0};
              if (bit_q == `BYTE_BITS) begin
                bit_d = 4'h0;
                if (!sda) begin
                  case (what_q)
                    ee_pkg::W_CTRLW: begin
                      if (op == ee_pkg::OP_POLL) begin
                        ms_d = ee_pkg::M_STOP;
                      end else begin
                        what_d = ee_pkg::W_AH;
                      end
                    end
                    ee_pkg::W_AH: what_d = ee_pkg::W_AL;
                    ee_pkg::W_AL: begin
                      if (op == ee_pkg::OP_WRITE) begin
                        what_d = ee_pkg::W_DATA;
                      end else begin
                        what_d = ee_pkg::W_CTRLR;
                        ms_d = ee_pkg::M_START;
                      end
                    end
                    ee_pkg::W_CTRLR: ms_d = ee_pkg::M_RECV;
                    default: ms_d = ee_pkg::M_STOP;
                  endcase
                  sh_d = tx_byte(what_d, cmd_q, wb_q);
                end else if (op == ee_pkg::OP_POLL) begin
                  // busy: start and addressing byte again
                  ms_d = ee_pkg::M_START;
                end else begin
                  nack_d = 1'b1;
                  ms_d = ee_pkg::M_STOP;
                end
              end
            end
            default: ;
          endcase
        end
      end
      ee_pkg::M_RECV: begin
        if (tick) begin
          case (ph_q)
            // ack while bytes remain, else nack
            2'h0: sda_oe_d = (bit_q == `BYTE_BITS) && (left_q != 8'h00);
            2'h2: scl_oe_d = 1'b0;
            2'h3: begin
              scl_oe_d = 1'b1;
              bit_d = bit_q + 1'b1;
              if (bit_q < `BYTE_BITS) begin
                sh_d = {sh_q[6:0], sda};
                if (bit_q == `BYTE_BITS - 4'h1) begin
                  if (full_q) begin
                    ms_d = ee_pkg::M_WAIT;
                  end else begin
                    byte_d = sh_d;
                    set_full = 1'b1;
                  end
                end
              end else begin
                bit_d = 4'h0;
                if (left_q == 8'h00) begin
                  ms_d = ee_pkg::M_STOP;
                end else begin
                  left_d = left_q - 1'b1;
                end
              end
            end
            default: ;
          endcase
        end
      end
      ee_pkg::M_WAIT: begin
        // clock held low until software takes the last byte
        ph_d = 2'h0;
        if (tick && !full_q) begin
          byte_d = sh_q;
          set_full = 1'b1;
          ms_d = ee_pkg::M_RECV;
        end
      end
      default: begin
        if (tick) begin
          case (ph_q)
            2'h0: sda_oe_d = 1'b1;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b0;
            default: ms_d = ee_pkg::M_IDLE;
          endcase
        end
      end
    endcase
    // a new byte wins over a clearing read
    full_d = set_full || (full_q && !clr_full);
  end

  assign tick = div_q == DW'(QUARTER - 1);

  // all controller registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {aw_ok_q, awa_q, w_ok_q, wd_q, ws_q, bv_q, br_q, rv_q, rd_q, rr_q} <= '0;
      {cmd_q, wb_q, go_q, byte_q, full_q, nack_q} <= '0;
      {ph_q, bit_q, sh_q, left_q, div_q, scl_oe_q, sda_oe_q} <= '0;
      ms_q <= ee_pkg::M_IDLE;
      what_q <= ee_pkg::W_CTRLW;
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      {aw_ok_q, awa_q, w_ok_q, wd_q, ws_q} <= {aw_ok_d, awa_d, w_ok_d, wd_d, ws_d};
      {bv_q, br_q, rv_q, rd_q, rr_q} <= {bv_d, br_d, rv_d, rd_d, rr_d};
      {cmd_q, wb_q, go_q, byte_q, full_q, nack_q} <= {cmd_d, wb_d, go_d, byte_d, full_d, nack_d};
      {ph_q, bit_q, sh_q, left_q, div_q} <= {ph_d, bit_d, sh_d, left_d, div_d};
      {scl_oe_q, sda_oe_q} <= {scl_oe_d, sda_oe_d};
      ms_q <= ms_d;
      what_q <= what_d;
      s1_q <= bus.sda;
      s2_q <= s1_q;
    end
  end

  // outputs
  assign sda = s2_q;
  assign bus.m_scl_o = `OD_LOW;
  assign bus.m_sda_o = `OD_LOW;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_oe = sda_oe_q;
  assign o_bvalid = bv_q;
  assign o_bresp = br_q;
  assign o_rvalid = rv_q;
  assign o_rdata = rd_q;
  assign o_rresp = rr_q;
endmodule
`default_nettype wire

/* ee_link_properties.sv */
// assertions watching the two-wire link between controller and memory
`timescale 1ns/10ps
`default_nettype none
module ee_link_properties #(
  parameter int PROG_CYCLES = 600
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // link signals
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda,
  // memory programming flag
  input wire logic o_busy
);
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // length of the current programming cycle
  always_comb busy_cnt_d = o_busy ? busy_cnt_q + 16'h1 : 16'h0;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_cnt_q <= 16'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  // link checks
  property p_busy_silent; o_busy |-> !d_sda_oe; endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("ack while busy");
  property p_busy_at_stop; $rose(o_busy) |-> scl && sda; endproperty
  a_busy_at_stop: assert property (p_busy_at_stop) else $error("busy not at stop");
  property p_busy_len;
    $fell(o_busy) |-> (busy_cnt_q + 16'h1 >= PROG_CYCLES) && (busy_cnt_q <= PROG_CYCLES + 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_od_low; !m_scl_o && !m_sda_o && !d_sda_o; endproperty
  a_od_low: assert property (p_od_low) else $error("line driven high");
  property p_scl_high; $rose(scl) |-> scl [*6]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_pull_low; $rose(d_sda_oe) |-> !scl; endproperty
  a_pull_low: assert property (p_pull_low) else $error("device pulls in clock high");
  property p_data_stable;
    scl && $past(scl) && $changed(sda) |-> !d_sda_oe && !$past(d_sda_oe);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("device moved data");
  property p_stop_free; scl && $rose(sda) |-> !d_sda_oe; endproperty
  a_stop_free: assert property (p_stop_free) else $error("line held at stop");
  property p_start_free; scl && $fell(sda) |-> !d_sda_oe && !$past(d_sda_oe); endproperty
  a_start_free: assert property (p_start_free) else $error("line held at start");
  property p_idle_reset; $rose(i_reset_n) |-> scl && sda; endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("lines low after reset");
  // main scenarios reached
  c_prog: cover property ($fell(o_busy));
  c_ack: cover property ($rose(d_sda_oe));
  c_stop: cover property (scl && $rose(sda));
endmodule
`default_nettype wire

/* serial_eeprom_read_and_ack_poll_tb_top.sv */
// self-checking bench: controller and memory joined over the two-wire link
`timescale 1ns/10ps
`default_nettype none
`include "ee_cfg.svh"
module serial_eeprom_read_and_ack_poll_tb_top;
  typedef struct packed {logic [1:0] op; logic [11:0] addr;
    logic [7:0] cnt; logic [11:0] loc;} row_t;
  localparam int PROG = 600;
  localparam logic [2:0] SEL = 3'h2;
  logic i_clk, i_reset_n, awvalid, wvalid, bready, arvalid, rready, busy_was;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] sel_pins;
  int fail_count, checked, busy_rises, rises0;
  logic [11:0] locs [6] = '{12'h123, 12'h124, 12'hFFF, 12'h000, 12'h001, 12'h002};
  row_t rows [4] = '{'{ee_pkg::OP_RAND_READ, 12'h123, 8'h0, 12'h123},
    '{ee_pkg::OP_CUR_READ, 12'h0, 8'h0, 12'h124}, '{ee_pkg::OP_RAND_READ, 12'hFFF, 8'h2, 12'hFFF},
    '{ee_pkg::OP_CUR_READ, 12'h0, 8'h0, 12'h002}};
  two_wire_if two_wire_if_inst();
  ee_master #(.QUARTER(8)) ee_master_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .bus(two_wire_if_inst.master));
  ee_dev #(.PROG_CYCLES(PROG)) ee_dev_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_chip_select_hi_pin(sel_pins[2]), .i_chip_select_mid_pin(sel_pins[1]),
    .i_chip_select_lo_pin(sel_pins[0]), .bus(two_wire_if_inst.device), .o_busy(busy));
  ee_link_properties #(.PROG_CYCLES(PROG)) ee_link_properties_inst (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .m_scl_o(two_wire_if_inst.m_scl_o),
    .m_scl_oe(two_wire_if_inst.m_scl_oe), .m_sda_o(two_wire_if_inst.m_sda_o),
    .m_sda_oe(two_wire_if_inst.m_sda_oe), .d_sda_o(two_wire_if_inst.d_sda_o),
    .d_sda_oe(two_wire_if_inst.d_sda_oe), .scl(two_wire_if_inst.scl),
    .sda(two_wire_if_inst.sda), .o_busy(busy));
  // clock
  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  // counts programming cycles as they start
  always @(posedge i_clk) begin
    busy_was <= busy;
    if (busy === 1'h1 && busy_was !== 1'h1) busy_rises <= busy_rises + 1;
  end
  // stored byte pattern for a location
  function automatic logic [7:0] dat(input logic [11:0] l);
    return l[7:0] ^ {l[11:8], 4'h5};
  endfunction
  function automatic logic [31:0] cmd(input logic [1:0] op, input logic [2:0] s,
    input logic [7:0] c, input logic [11:0] a);
    return {4'h0, a, c, 1'h0, s, 2'h0, op};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic do_reset();
    i_reset_n <= 1'h0;
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'h1;
  endtask
  // register write, waits for the response
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  // register read, data taken at the rvalid edge
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    v = rdata;
    q = rresp;
    rready <= 1'h0;
  endtask
  task automatic idle();
    logic [31:0] s;
    logic [1:0] q;
    do axr(`REG_STATUS, s, q); while (s[`ST_BUSY] !== 1'h0);
  endtask
  // one read command, every byte compared
  task automatic rd_row(input row_t w);
    logic [31:0] s;
    logic [1:0] q;
    axw(`REG_CMD, cmd(w.op, SEL, w.cnt, w.addr), `RESP_OKAY);
    for (int i = 0; i <= w.cnt; i++) begin
      do axr(`REG_STATUS, s, q); while (s[`ST_FULL] !== 1'h1);
      axr(`REG_RDATA, s, q);
      chk(s, {24'h0, dat(w.loc + 12'(i))});
    end
    idle();
    axr(`REG_STATUS, s, q);
    chk({31'h0, s[`ST_NACK]}, 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    sel_pins = SEL;
    i_reset_n = 1'h0;
    do_reset();
    axr(`REG_STATUS, d, r);
    chk(d, 32'h0);
    note("reset");
    foreach (locs[i]) begin
      axw(`REG_WDATA, {24'h0, dat(locs[i])}, `RESP_OKAY);
      axr(`REG_WDATA, d, r);
      chk(d, {24'h0, dat(locs[i])});
      rises0 = busy_rises;
      axw(`REG_CMD, cmd(ee_pkg::OP_WRITE, SEL, 8'h0, locs[i]), `RESP_OKAY);
      idle();
      axw(`REG_CMD, cmd(ee_pkg::OP_POLL, SEL, 8'h0, 12'h0), `RESP_OKAY);
      idle();
      chk(32'(busy_rises - rises0), 32'h1);
      chk({31'h0, busy}, 32'h0);
    end
    note("write and poll");
    foreach (rows[i]) rd_row(rows[i]);
    note("read rows");
    rises0 = busy_rises;
    axw(`REG_CMD, cmd(ee_pkg::OP_WRITE, 3'h5, 8'h0, 12'h123), `RESP_OKAY);
    idle();
    axr(`REG_STATUS, d, r);
    chk({31'h0, d[`ST_NACK]}, 32'h1);
    chk(32'(busy_rises - rises0), 32'h0);
    rd_row('{ee_pkg::OP_RAND_READ, 12'h123, 8'h1, 12'h123});
    note("select mismatch");
    // slow software: controller holds the clock low until a byte is taken
    axw(`REG_CMD, cmd(ee_pkg::OP_RAND_READ, SEL, 8'h1, 12'hFFF), `RESP_OKAY);
    repeat (2500) @(posedge i_clk);
    axr(`REG_STATUS, d, r);
    chk(d, 32'h5);
    for (int i = 0; i < 2; i++) begin
      axr(`REG_RDATA, d, r);
      chk(d, {24'h0, dat(12'hFFF + 12'(i))});
      repeat (400) @(posedge i_clk);
    end
    idle();
    note("stalled read");
    axw(8'h10, 32'h0, `RESP_SLVERR);
    axr(8'h10, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    note("unmapped");
    do_reset();
    axr(`REG_STATUS, d, r);
    chk(d, 32'h0);
    note("second reset");
    summarize();
  end
endmodule
`default_nettype wire
